// ===== common/acsreg_defs.svh
// Offsets, field positions, reset values and the operation list of the ACS register bank.
//
// Operation
// RULE1: Three 32-bit words at 520h, 524h, 528h; 52Ch reads as reserved zero.
// RULE2: Downstream header bits 15:0 read fixed capability identifier 000Dh.
// RULE3: Downstream header bits 19:16 read fixed capability version 1h.
// RULE4: Downstream header bits 31:20 read fixed next pointer 950h.
// RULE5: Header shared by all ports; port 0 reads every field as zero.
// RULE6: Word 524h holds capability bits low, control bits high.
// RULE7: Downstream capability bits 0 to 6 read as fixed ones.
// RULE8: Bits 10:8 egress vector size, loaded at reset to 100b.
// RULE9: Configuring party sets egress vector size to match port configuration.
// RULE10: Downstream control bits 16 to 22 are writable enables resetting to zero.
// RULE11: Egress vector bits 3:0 are writable per-port controls resetting to zero.
// RULE12: Egress controls take effect only while control bit 21 is set.
// RULE13: Reserved bits read zero and ignore writes.
`ifndef ACSREG_DEFS_SVH
`define ACSREG_DEFS_SVH

`define ACSREG_OFS_HEADER   12'h520
`define ACSREG_OFS_CAPCTL   12'h524
`define ACSREG_OFS_EGRESS   12'h528
`define ACSREG_OFS_RSVD     12'h52c
`define ACSREG_CAP_ID       16'h000d
`define ACSREG_CAP_VER      4'h1
`define ACSREG_NEXT_PTR     12'h950
`define ACSREG_CAP_BITS     7'h7f
`define ACSREG_VSIZE_RST    3'h4
`define ACSREG_VSIZE_LSB    8
`define ACSREG_CTL_LSB      16
`define ACSREG_CTL_EGR_BIT  5

`endif

// ===== common/acsreg_pkg.sv
// Types of the ACS register bank.
`default_nettype none
package acsreg_pkg;
   typedef struct packed {
      logic [2:0] vsize;
      logic [6:0] ctl;
      logic [3:0] egress;
      logic [31:0] rdata;
   } acsreg_state_type;
endpackage
`default_nettype wire

// ===== rtl/acsreg_bank.sv
// ACS extended capability register bank for one switch port.
`include "acsreg_defs.svh"
`default_nettype none
module acsreg_bank
   import acsreg_pkg::*;
#(
   parameter int NUM_EGRESS = 4
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset,
   input  wire logic        i_is_port0,
   input  wire logic        i_cfg_wr,
   input  wire logic        i_cfg_rd,
   input  wire logic [11:0] i_cfg_addr,
   input  wire logic [31:0] i_cfg_wdata,
   input  wire logic [3:0]  i_cfg_be,
   output logic      [31:0] o_cfg_rdata,
   output logic      [6:0]  o_acs_enables,
   output logic      [3:0]  o_egress_active,
   output logic      [2:0]  o_egress_vsize
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   acsreg_state_type st_r;
   acsreg_state_type st_nxt;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   // Port 0 has no writable field, so the strobes are qualified here for the checks; the next-state logic and read_word qualify them again.
   logic wr_down;
   logic rd_down;
   logic wr_capctl;
   logic wr_egress;

   assign wr_down   = i_cfg_wr && !i_is_port0; // RULE5
   assign rd_down   = i_cfg_rd && !i_is_port0;
   assign wr_capctl = wr_down && (i_cfg_addr == `ACSREG_OFS_CAPCTL);
   assign wr_egress = wr_down && (i_cfg_addr == `ACSREG_OFS_EGRESS);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Ports beyond the configured count have no control bit, so those bits are tied to zero.
   function automatic logic [3:0] egress_mask();
      logic [3:0] m;
      m = 4'h0;
      for (int k = 0; k < 4; k++) begin
         m[k] = (k < NUM_EGRESS);
      end
      return m;
   endfunction

   function automatic logic [31:0] read_word(input logic [11:0] a, input acsreg_state_type s,
                                             input logic p0);
      logic [31:0] w;
      w = 32'h0;
      if (!p0) begin // RULE5
         case (a)
            `ACSREG_OFS_HEADER: begin
               w[15:0]  = `ACSREG_CAP_ID; // RULE2
               w[19:16] = `ACSREG_CAP_VER; // RULE3
               w[31:20] = `ACSREG_NEXT_PTR; // RULE4
            end
            `ACSREG_OFS_CAPCTL: begin
               w[6:0]                    = `ACSREG_CAP_BITS; // RULE7
               w[`ACSREG_VSIZE_LSB +: 3] = s.vsize; // RULE8
               w[`ACSREG_CTL_LSB +: 7]   = s.ctl; // RULE6
            end
            `ACSREG_OFS_EGRESS: begin
               w[3:0] = s.egress; // RULE11
            end
            default: begin
               w = 32'h0; // RULE1
            end
         endcase
      end
      return w;
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // Port 0 ignores writes so its hidden fields stay at their reset values.
      if (i_cfg_wr && !i_is_port0) begin
         if (i_cfg_addr == `ACSREG_OFS_CAPCTL) begin
            if (i_cfg_be[1]) begin
               st_nxt.vsize = i_cfg_wdata[10:8]; // RULE8
            end
            if (i_cfg_be[2]) begin
               st_nxt.ctl = i_cfg_wdata[22:16]; // RULE10
            end
         end
         if (i_cfg_addr == `ACSREG_OFS_EGRESS && i_cfg_be[0]) begin
            st_nxt.egress = i_cfg_wdata[3:0] & egress_mask(); // RULE11
         end
      end
      st_nxt.rdata = i_cfg_rd ? read_word(i_cfg_addr, st_r, i_is_port0) : st_r.rdata; // RULE13
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         st_r.vsize  <= `ACSREG_VSIZE_RST; // RULE8
         st_r.ctl    <= 7'h0;
         st_r.egress <= 4'h0;
         st_r.rdata  <= 32'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_cfg_rdata     = st_r.rdata;
   assign o_acs_enables   = i_is_port0 ? 7'h0 : st_r.ctl;
   // Egress bits are gated here so the routing logic never sees stale controls.
   assign o_egress_active = (st_r.ctl[`ACSREG_CTL_EGR_BIT] && !i_is_port0) ? st_r.egress
                                                                          : 4'h0; // RULE12
   assign o_egress_vsize  = st_r.vsize;

   // ------------------------------------------------------------
   // Checks on reads
   // ------------------------------------------------------------
   hdr_read_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE2
      i_cfg_rd && !i_is_port0 && i_cfg_addr == 12'h520 |=> o_cfg_rdata == 32'h9501000d)
      else $error("header word wrong");

   port0_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
      i_cfg_rd && i_is_port0 |=> o_cfg_rdata == 32'h0) else $error("port 0 not zero");

   cap_ones_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE7
      i_cfg_rd && !i_is_port0 && i_cfg_addr == 12'h524 |=> o_cfg_rdata[7:0] == 8'h7f)
      else $error("capability bits wrong");

   rsvd_word_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE1
      i_cfg_rd && i_cfg_addr == 12'h52c |=> o_cfg_rdata == 32'h0) else $error("52c not zero");

   ctl_rsvd_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE13
      i_cfg_rd && i_cfg_addr == 12'h524 ##1 1'b1 |-> o_cfg_rdata[31:23] == 9'h0
      && o_cfg_rdata[15:11] == 5'h0) else $error("reserved bits set");

   egress_rsvd_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE11
      i_cfg_rd && i_cfg_addr == 12'h528 |=> o_cfg_rdata[31:4] == 28'h0)
      else $error("egress reserved bits set");

   ctl_read_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE6
      rd_down && i_cfg_addr == 12'h524 |=> o_cfg_rdata[22:16] == $past(st_r.ctl)
      && o_cfg_rdata[10:8] == $past(st_r.vsize)) else $error("control word read wrong");

   egress_read_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE11
      rd_down && i_cfg_addr == 12'h528 |=> o_cfg_rdata[3:0] == $past(st_r.egress))
      else $error("egress vector read wrong");

   // Offsets outside the three words answer zero rather than aliasing onto them.
   other_addr_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE1
      i_cfg_rd && i_cfg_addr != 12'h520 && i_cfg_addr != 12'h524 && i_cfg_addr != 12'h528
      |=> o_cfg_rdata == 32'h0) else $error("unmapped offset not zero");

   rdata_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE1
      !i_cfg_rd |=> $stable(o_cfg_rdata)) else $error("read data not held");

   // ------------------------------------------------------------
   // Checks on writes and outputs
   // ------------------------------------------------------------
   ctl_write_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE10
      i_cfg_wr && !i_is_port0 && i_cfg_addr == 12'h524 && i_cfg_be[2]
      |=> o_acs_enables == $past(i_cfg_wdata[22:16])) else $error("control write lost");

   vsize_write_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE8
      wr_capctl && i_cfg_be[1] |=> o_egress_vsize == $past(i_cfg_wdata[10:8]))
      else $error("vector size write lost");

   // Fields change only through a write that addresses their own byte.
   vsize_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE13
      !(wr_capctl && i_cfg_be[1]) |=> $stable(o_egress_vsize))
      else $error("vector size changed without write");

   egress_write_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE11
      wr_egress && i_cfg_be[0] |=> st_r.egress == ($past(i_cfg_wdata[3:0]) & egress_mask()))
      else $error("egress vector write lost");

   egress_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE13
      !(wr_egress && i_cfg_be[0]) |=> $stable(st_r.egress))
      else $error("egress vector changed without write");

   ctl_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE10
      !(wr_capctl && i_cfg_be[2]) |=> $stable(st_r.ctl))
      else $error("control bits changed without write");

   rsvd_write_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE13
      i_cfg_wr && (i_cfg_addr == 12'h520 || i_cfg_addr == `ACSREG_OFS_RSVD) |=> $stable(st_r.ctl)
      && $stable(st_r.egress) && $stable(st_r.vsize)) else $error("header write landed");

   // The hidden fields of port 0 must not move, or they would surface if the port role changed.
   port0_write_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
      i_cfg_wr && i_is_port0 |=> $stable(st_r.ctl) && $stable(st_r.egress)
      && $stable(st_r.vsize)) else $error("port 0 write landed");

   port0_out_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
      i_is_port0 |-> o_acs_enables == 7'h0 && o_egress_active == 4'h0)
      else $error("port 0 outputs not zero");

   egress_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE12
      !o_acs_enables[5] |-> o_egress_active == 4'h0) else $error("egress ungated");

   egress_pass_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE12
      o_acs_enables[5] |-> o_egress_active == st_r.egress)
      else $error("egress controls blocked");

   enables_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE10
      !i_is_port0 |-> o_acs_enables == st_r.ctl)
      else $error("enables do not follow control bits");

   egress_unused_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE13
      (st_r.egress & ~egress_mask()) == 4'h0)
      else $error("unimplemented egress bit set");

endmodule
`default_nettype wire

// ===== test/tb_acsreg_bank.sv
// Self-checking bench for the ACS register bank.
`default_nettype none
module tb_acsreg_bank;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, p0 = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [11:0] a   = 12'h000;
   logic [31:0] wd  = 32'h0, rdata;
   logic [3:0]  be  = 4'h0, eg;
   logic [6:0]  en;
   logic [2:0]  vs;
   int          fails = 0, n_tests = 0, cyc = 0;
   acsreg_bank acsreg_bank_inst (.i_sys_clk(clk), .i_reset(rst), .i_is_port0(p0),
      .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(a), .i_cfg_wdata(wd), .i_cfg_be(be),
      .o_cfg_rdata(rdata), .o_acs_enables(en), .o_egress_active(eg), .o_egress_vsize(vs));
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One request per call; a cycle passes between calls so strobes never re-rise in one step.
   task automatic op(input logic w, input logic [11:0] ad, input logic [31:0] d,
                     input logic [3:0] b);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      a  <= ad;
      wd <= d;
      be <= b;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
      op(1'b0, ad, 32'h0, 4'h0);
      chk("rdata", rdata, exp);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         results();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rdc(12'h520, 32'h9501000d);
      rdc(12'h524, 32'h0000047f);
      rdc(12'h528, 32'h0);
      rdc(12'h52c, 32'h0);
   endtask
   // Egress bits only act while the egress enable is set, so toggle it under a full vector.
   task automatic t_write();
      op(1'b1, 12'h524, 32'hffffffff, 4'hf);
      op(1'b1, 12'h528, 32'hffffffff, 4'hf);
      chk("egress", {28'h0, eg}, 32'hf);
      rdc(12'h524, 32'h007f077f);
      rdc(12'h528, 32'h0000000f);
      op(1'b1, 12'h524, 32'h0, 4'h4);
      chk("egress", {28'h0, eg}, 32'h0);
      chk("vsize", {29'h0, vs}, 32'h7);
      op(1'b1, 12'h520, 32'h0, 4'hf);
      op(1'b1, 12'h52c, 32'hffffffff, 4'hf);
      rdc(12'h520, 32'h9501000d);
      rdc(12'h52c, 32'h0);
   endtask
   // A mid-run reset must bring every field back to its reset value.
   task automatic t_rst();
      op(1'b1, 12'h524, 32'h00200600, 4'h6);
      chk("enables", {25'h0, en}, 32'h20);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("enables", {25'h0, en}, 32'h0);
      chk("egress", {28'h0, eg}, 32'h0);
      chk("vsize", {29'h0, vs}, 32'h4);
      rdc(12'h528, 32'h0);
   endtask
   // Port 0 drops writes, so a return to the downstream view proves nothing landed.
   task automatic t_port0();
      @(posedge clk);
      p0 <= 1'b1;
      op(1'b1, 12'h524, 32'h00200000, 4'h4);
      op(1'b1, 12'h528, 32'h0000000f, 4'h1);
      chk("enables", {25'h0, en}, 32'h0);
      rdc(12'h520, 32'h0);
      rdc(12'h524, 32'h0);
      rdc(12'h528, 32'h0);
      @(posedge clk);
      p0 <= 1'b0;
      #1;
      chk("enables", {25'h0, en}, 32'h0);
      rdc(12'h528, 32'h0);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_write();
      t_rst();
      t_port0();
      results();
   end
endmodule
`default_nettype wire
